// File: rts_partner.sv
// Far-side model: supply detectors, master clear pin and crystal.
`timescale 1ns/1ps
module rts_partner (
  // Detector and pin levels.
  output logic por_pulse,
  output logic brownout_det,
  output logic master_clear_n,
  // Crystal output.
  output logic osc_in
);
  initial begin
    por_pulse = 1'b1;
    brownout_det = 1'b0;
    master_clear_n = 1'b1;
    osc_in = 1'b0;
  end
  // The crystal runs free and out of phase with the system clock, so edges land anywhere.
  always #11.5 osc_in = ~osc_in;
  // Levels move only when the bench asks, just after a clock edge.
  task drive(input logic por, input logic bo, input logic master_clear_n_n);
    por_pulse <= por;
    brownout_det <= bo;
    master_clear_n <= master_clear_n_n;
  endtask : drive
endmodule : rts_partner

// File: rts_pkg.sv
// Constants and types for the reset time-out sequencer.
// Function
// - Chip held in reset during power-up delay.
// - Delay timer ticks from internal RC divider.
// - Enable-low setting applies 72 ms delay.
// - Start counter counts 1024 oscillator cycles.
// - Start count only for crystal modes.
// - Power-on wait, then delay, then start.
// - RC mode, delay off: no hold.
// - Brown-out enable setting gates brown-out reset.
// - Brown-out holds reset, then full delay.
// - Brown-out during delay restarts the timer.
// - Master clear after delays releases immediately.
// - Status bit0 is active-low brown-out flag.
// - Software may write the brown-out flag.
// - Bit1 power-on flag, cleared on power-on.
// - Timeout and power-down flags per cause.
// - Program counter load per reset or wake.
// - Status register image per reset cause.
// - Power status two bits, per-cause values.
// - Watchdog never drives master clear; filtered.
package rts_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RCOSC_TICK_NS = 1000;
  localparam int RCOSC_DIV = (RCOSC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUP_DELAY_MS = 72;
  localparam int PUP_TICKS = (PUP_DELAY_MS * 1000000 + RCOSC_TICK_NS - 1) / RCOSC_TICK_NS;
  localparam int START_CYCLES = 1024;
  localparam int FILT_NS = 20;
  localparam int FILT_CYCLES = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  REG_PWR_STATUS = 8'h00;
  localparam logic [7:0]  REG_SEQ_STATUS = 8'h04;
  localparam int          BIT_BO_N       = 0;
  localparam int          BIT_POR_N      = 1;

  localparam logic [1:0]  OSC_LOWPWR = 2'h0;
  localparam logic [1:0]  OSC_CRYSTAL = 2'h1;
  localparam logic [1:0]  OSC_HISPEED = 2'h2;
  localparam logic [1:0]  OSC_RESCAP = 2'h3;

  localparam int          PC_W       = 13;
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;

  // Status images: value, and mask of bits left unchanged.
  localparam logic [7:0] SV_POR = 8'h18, SK_POR = 8'h07;
  localparam logic [7:0] SV_MRUN = 8'h00, SK_MRUN = 8'h1f;
  localparam logic [7:0] SV_MSLP = 8'h10, SK_MSLP = 8'h07;
  localparam logic [7:0] SV_WRST = 8'h08, SK_WRST = 8'h07;
  localparam logic [7:0] SV_WWAKE = 8'h00, SK_WWAKE = 8'he7;
  localparam logic [7:0] SV_BO = 8'h18, SK_BO = 8'h07;
  localparam logic [7:0] SV_IWAKE = 8'h10, SK_IWAKE = 8'he7;

  typedef enum logic [7:0] {
    ST_POR   = 8'h01,
    ST_BO    = 8'h02,
    ST_PUP   = 8'h04,
    ST_OSCW  = 8'h08,
    ST_MCLEAR = 8'h10,
    ST_WDOG  = 8'h20,
    ST_RUN   = 8'h40,
    ST_SLEEP = 8'h80
  } rts_state_t;

  typedef enum logic [2:0] {
    C_POR = 3'h0, C_BO = 3'h1, C_MRUN = 3'h2, C_MSLP = 3'h3,
    C_WRST = 3'h4, C_WWAKE = 3'h5, C_IWAKE = 3'h6
  } rts_cause_t;
endpackage : rts_pkg

// File: rts_top.sv
// Reset time-out sequencer with power status register on APB.
`timescale 1ns/1ps
module rts_top #(
  parameter int PUP_TICKS_P   = rts_pkg::PUP_TICKS,
  parameter int RCOSC_DIV_P   = rts_pkg::RCOSC_DIV,
  parameter int START_CYCLES_P = rts_pkg::START_CYCLES,
  parameter int FILT_CYCLES_P = rts_pkg::FILT_CYCLES
) (
  // Clock and reset.
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // APB slave.
  input  wire logic [rts_pkg::ADDR_W-1:0] PADDR,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // Asynchronous detectors and pins.
  input  wire logic                       POR_PULSE,
  input  wire logic                       BROWNOUT_DET,
  input  wire logic                       MASTER_CLEAR_N,
  input  wire logic                       OSCILLATOR_INPUT,
  // Static configuration.
  input  wire logic [1:0]                 OSC_MODE,
  input  wire logic                       POWER_UP_TIMER_ENABLE_N,
  input  wire logic                       BROWNOUT_ENABLE_CFG,
  // Core events, same clock.
  input  wire logic                       SLEEP_ENTER,
  input  wire logic                       WATCHDOG_TIMEOUT,
  input  wire logic                       WAKE_IRQ,
  input  wire logic                       GLOBAL_IRQ_ENABLE,
  input  wire logic [rts_pkg::PC_W-1:0]   CUR_PC,
  // Reset and load outputs.
  output logic                            CHIP_RESET,
  output logic                            CPU_RUN,
  output logic                            PC_LOAD,
  output logic      [rts_pkg::PC_W-1:0]   PC_VALUE,
  output logic                            STATUS_LOAD,
  output logic      [7:0]                 STATUS_VALUE,
  output logic      [7:0]                 STATUS_KEEP,
  output logic                            TIMEOUT_FLAG_N,
  output logic                            POWERDOWN_FLAG_N
);
  import rts_pkg::*;

  localparam int PUP_W   = $clog2(PUP_TICKS_P + 1);
  localparam int DIV_W   = $clog2(RCOSC_DIV_P + 1);
  localparam int START_W = $clog2(START_CYCLES_P + 1);
  localparam int FILT_W  = $clog2(FILT_CYCLES_P + 1);

  rts_state_t       state;
  rts_state_t       next_state;
  rts_cause_t       cause;
  rts_cause_t       next_cause;
  logic             por_s1, por_s2;
  logic             bo_s1, bo_s2;
  logic             mc_s1, mc_s2;
  logic             osc_s1, osc_s2, osc_s3;
  logic             master_clear_n_ok;
  logic [FILT_W-1:0] filt_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic [PUP_W-1:0] pup_cnt;
  logic [START_W-1:0] start_cnt;
  logic             bo_flag_n;
  logic             por_flag_n;
  logic             next_to_n;
  logic             next_pd_n;

  // Synchronisers; the first stage feeds only the second.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // The power-on path comes out of reset asserted, so the sequencer waits for the pin itself.
      {por_s1, por_s2, bo_s1, bo_s2} <= 4'hc;
      {mc_s1, mc_s2} <= 2'h0;
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
    end else begin
      por_s1 <= POR_PULSE;
      por_s2 <= por_s1;
      bo_s1  <= BROWNOUT_DET;
      bo_s2  <= bo_s1;
      mc_s1  <= MASTER_CLEAR_N;
      mc_s2  <= mc_s1;
      osc_s1 <= OSCILLATOR_INPUT;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  wire bo_active = BROWNOUT_ENABLE_CFG & bo_s2;
  wire osc_rise  = osc_s2 & ~osc_s3;
  wire xtal      = (OSC_MODE != OSC_RESCAP);
  wire pup_on    = ~POWER_UP_TIMER_ENABLE_N;

  // Master clear glitch filter: the level must hold for a run of cycles.
  wire filt_diff = (mc_s2 != master_clear_n_ok);
  wire filt_done = filt_diff && (filt_cnt == FILT_W'(FILT_CYCLES_P - 1));
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      filt_cnt <= '0;
      master_clear_n_ok  <= 1'b0;
    end else begin
      filt_cnt <= (filt_diff && !filt_done) ? filt_cnt + 1'b1 : '0;
      if (filt_done) begin
        master_clear_n_ok <= mc_s2;
      end
    end
  end

  // Slow tick standing in for the internal RC oscillator; it never
  // depends on the oscillator input, so a dead crystal cannot stall it.
  wire tick = (div_cnt == DIV_W'(RCOSC_DIV_P - 1));
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
    end
  end

  wire pup_done   = tick && (pup_cnt == PUP_W'(PUP_TICKS_P - 1));
  wire start_done = osc_rise && (start_cnt == START_W'(START_CYCLES_P - 1));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pup_cnt <= '0;
    end else if (state != ST_PUP) begin
      pup_cnt <= '0;
    end else if (tick) begin
      pup_cnt <= pup_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      start_cnt <= '0;
    end else if (state != ST_OSCW) begin
      start_cnt <= '0;
    end else if (osc_rise) begin
      start_cnt <= start_cnt + 1'b1;
    end
  end

  // Events seen from run and sleep.
  wire in_run    = (state == ST_RUN);
  wire in_sleep  = (state == ST_SLEEP);
  wire ev_mrun   = in_run && !master_clear_n_ok;
  wire ev_mslp   = in_sleep && !master_clear_n_ok;
  wire ev_wrst   = in_run && master_clear_n_ok && WATCHDOG_TIMEOUT;
  wire ev_wwake  = in_sleep && master_clear_n_ok && WATCHDOG_TIMEOUT;
  wire ev_iwake  = in_sleep && master_clear_n_ok && !WATCHDOG_TIMEOUT && WAKE_IRQ;
  wire ev_sleep  = in_run && master_clear_n_ok && !WATCHDOG_TIMEOUT && SLEEP_ENTER;
  wire ev_wake   = ev_wwake || ev_iwake;
  wire hold_free = !por_s2 && !bo_active;

  rts_state_t after_delay;
  rts_state_t after_start;
  assign after_start = master_clear_n_ok ? ST_RUN : ST_MCLEAR;
  assign after_delay = xtal ? ST_OSCW : after_start;

  always_comb begin
    next_state = state;
    if (por_s2) begin
      next_state = ST_POR;
    end else if (bo_active) begin
      next_state = ST_BO;
    end else begin
      case (state)
        ST_POR: begin
          next_state = pup_on ? ST_PUP : after_delay;
        end
        ST_BO: begin
          next_state = ST_PUP;
        end
        ST_PUP: begin
          if (pup_done) begin
            next_state = after_delay;
          end
        end
        ST_OSCW: begin
          if (start_done) begin
            next_state = after_start;
          end
        end
        ST_MCLEAR: begin
          if (master_clear_n_ok) begin
            next_state = ST_RUN;
          end
        end
        ST_WDOG: begin
          next_state = after_start;
        end
        ST_RUN: begin
          if (ev_mrun) begin
            next_state = ST_MCLEAR;
          end else if (ev_wrst) begin
            next_state = ST_WDOG;
          end else if (ev_sleep) begin
            next_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (ev_mslp) begin
            next_state = ST_MCLEAR;
          end else if (ev_wake) begin
            next_state = xtal ? ST_OSCW : ST_RUN;
          end
        end
        default: begin
          next_state = ST_POR;
        end
      endcase
    end
  end

  always_comb begin
    next_cause = cause;
    if (por_s2) begin
      next_cause = C_POR;
    end else if (bo_active) begin
      next_cause = C_BO;
    end else if (ev_mrun) begin
      next_cause = C_MRUN;
    end else if (ev_mslp) begin
      next_cause = C_MSLP;
    end else if (ev_wrst) begin
      next_cause = C_WRST;
    end else if (ev_wwake) begin
      next_cause = C_WWAKE;
    end else if (ev_iwake) begin
      next_cause = C_IWAKE;
    end
  end

  // Timeout and power-down flags follow the cause of each event.
  always_comb begin
    next_to_n = TIMEOUT_FLAG_N;
    next_pd_n = POWERDOWN_FLAG_N;
    if (por_s2 || bo_active) begin
      {next_to_n, next_pd_n} = 2'h3;
    end else if (ev_wrst) begin
      {next_to_n, next_pd_n} = 2'h1;
    end else if (ev_wwake) begin
      {next_to_n, next_pd_n} = 2'h0;
    end else if (ev_mslp || ev_iwake || ev_sleep) begin
      {next_to_n, next_pd_n} = 2'h2;
    end
  end

  function automatic logic [15:0] status_image(input rts_cause_t c);
    case (c)
      C_POR:   status_image = {SV_POR, SK_POR};
      C_BO:    status_image = {SV_BO, SK_BO};
      C_MRUN:  status_image = {SV_MRUN, SK_MRUN};
      C_MSLP:  status_image = {SV_MSLP, SK_MSLP};
      C_WRST:  status_image = {SV_WRST, SK_WRST};
      C_WWAKE: status_image = {SV_WWAKE, SK_WWAKE};
      C_IWAKE: status_image = {SV_IWAKE, SK_IWAKE};
      default: status_image = {SV_POR, SK_POR};
    endcase
  endfunction : status_image

  wire        is_wake  = (next_cause == C_WWAKE) || (next_cause == C_IWAKE);
  wire        to_vec   = (next_cause == C_IWAKE) && GLOBAL_IRQ_ENABLE;
  wire [12:0] pc_next  = CUR_PC + 13'h0001;
  wire [12:0] pc_sel   = to_vec ? PC_IRQ_VEC : (is_wake ? pc_next : PC_RESET);
  wire [15:0] st_img   = status_image(next_cause);
  wire        release_ev = (next_state == ST_RUN) && (state != ST_RUN);
  wire        next_hold = (next_state != ST_RUN) && (next_state != ST_SLEEP) &&
                          !((next_state == ST_OSCW) && is_wake);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state            <= ST_POR;
      cause            <= C_POR;
      CHIP_RESET       <= 1'b1;
      CPU_RUN          <= 1'b0;
      PC_LOAD          <= 1'b0;
      PC_VALUE         <= PC_RESET;
      STATUS_LOAD      <= 1'b0;
      STATUS_VALUE     <= SV_POR;
      STATUS_KEEP      <= SK_POR;
      TIMEOUT_FLAG_N   <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
    end else begin
      state            <= next_state;
      cause            <= next_cause;
      CHIP_RESET       <= next_hold;
      CPU_RUN          <= (next_state == ST_RUN);
      PC_LOAD          <= release_ev;
      STATUS_LOAD      <= release_ev;
      TIMEOUT_FLAG_N   <= next_to_n;
      POWERDOWN_FLAG_N <= next_pd_n;
      if (release_ev) begin
        PC_VALUE     <= pc_sel;
        STATUS_VALUE <= st_img[15:8];
        STATUS_KEEP  <= st_img[7:0];
      end
    end
  end

  // APB slave: one wait state, so every access takes three cycles.
  wire acc_start = PSEL && PENABLE && !PREADY;
  wire commit    = PSEL && PENABLE && PREADY;
  wire hit_pwr   = (PADDR == REG_PWR_STATUS);
  wire hit_seq   = (PADDR == REG_SEQ_STATUS);
  wire wr_pwr    = commit && PWRITE && hit_pwr && !PSLVERR;
  wire [31:0] rd_pwr = {30'h0, por_flag_n, bo_flag_n};
  wire [31:0] rd_seq = {19'h0, cause, TIMEOUT_FLAG_N, POWERDOWN_FLAG_N, state};
  wire [31:0] rd_mux = hit_pwr ? rd_pwr : (hit_seq ? rd_seq : 32'h0);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= acc_start;
      PSLVERR <= acc_start && !(hit_pwr || hit_seq);
      PRDATA  <= (acc_start && !PWRITE) ? rd_mux : 32'h0;
    end
  end

  // Hardware events win over a software write in the same cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bo_flag_n  <= 1'b1;
      por_flag_n <= 1'b0;
    end else begin
      if (bo_active) begin
        bo_flag_n <= 1'b0;
      end else if (por_s2 && BROWNOUT_ENABLE_CFG) begin
        bo_flag_n <= 1'b1;
      end else if (wr_pwr) begin
        bo_flag_n <= PWDATA[BIT_BO_N];
      end
      if (por_s2) begin
        por_flag_n <= 1'b0;
      end else if (wr_pwr) begin
        por_flag_n <= PWDATA[BIT_POR_N];
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_bo_gone;
    bo_active ##1 (!bo_active && !por_s2);
  endsequence

  a_pup_hold: assert property ((state == ST_PUP) |-> CHIP_RESET)
    else $error("reset released while delay timer runs");
  a_tick_rate: assert property (tick |=> !tick [*2])
    else $error("slow tick faster than divider");
  a_pup_skip: assert property ($fell(por_s2) && !pup_on && !bo_active |=>
    state != ST_PUP)
    else $error("delay applied while disabled");
  a_start_exit: assert property ((state == ST_OSCW) && !start_done && hold_free
    && !ev_mslp |=> state == ST_OSCW)
    else $error("start count left early");
  a_start_mode: assert property ((state == ST_OSCW) |-> xtal)
    else $error("start count in RC mode");
  a_no_delay: assert property ((state == ST_POR) && hold_free && !xtal && !pup_on
    && master_clear_n_ok |=> CPU_RUN)
    else $error("RC mode without delay still held");
  a_bo_enter: assert property (bo_active && !por_s2 |=> (state == ST_BO) &&
    (cause == C_BO) && !bo_flag_n)
    else $error("brown-out not held in reset");
  a_bo_restart: assert property (s_bo_gone |=> (state == ST_PUP) &&
    (pup_cnt == '0))
    else $error("delay not restarted after brown-out");
  a_master_clear_n_fast: assert property ((state == ST_MCLEAR) && master_clear_n_ok && hold_free |=>
    CPU_RUN ##1 !PC_LOAD)
    else $error("master clear release delayed");
  a_por_flag: assert property (por_s2 |=> !por_flag_n && TIMEOUT_FLAG_N &&
    POWERDOWN_FLAG_N)
    else $error("power-on flags wrong");
  a_wdog_flags: assert property (ev_wrst && hold_free |=> !TIMEOUT_FLAG_N &&
    POWERDOWN_FLAG_N ##1 PC_LOAD && (PC_VALUE == PC_RESET))
    else $error("watchdog reset flags or pc wrong");
  a_irq_vector: assert property (PC_LOAD && (cause == C_IWAKE) &&
    $past(GLOBAL_IRQ_ENABLE) |-> PC_VALUE == PC_IRQ_VEC)
    else $error("interrupt wake missed vector");
  a_status_img: assert property (STATUS_LOAD && (cause == C_WRST) |->
    (STATUS_VALUE == SV_WRST) && (STATUS_KEEP == SK_WRST))
    else $error("watchdog status image wrong");
endmodule : rts_top

// File: rts_top_tb.sv
// Self-checking bench for the reset time-out sequencer.
`timescale 1ns/1ps
module rts_top_tb;
  import rts_pkg::*;
  localparam int PT = 20, DV = 4, SC = 8, FC = 4;
  localparam int PUP = PT * DV;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, status_value, status_keep;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0]  osc_mode = 2'h3;
  logic        pte_n = 1'b1, bo_en = 1'b1, sleep_in = 1'b0, wdog = 1'b0, wake = 1'b0;
  logic        global_irq_enable = 1'b0, pready, pslverr, por, bo, master_clear_n_n, osc;
  logic        chip_reset, cpu_run, pc_load, status_load, to_n, pd_n;
  logic [12:0] cur_pc = 13'h0, pc_value;
  logic [30:0] load_q[$];
  logic [33:0] apb_q[$];
  int          err_count = 0, comparisons = 0;
  wire  [32:0] load_seen = {status_load, chip_reset, pc_value, status_value, status_keep, to_n, pd_n};

  always #2.5 clk = ~clk;

  rts_top #(.PUP_TICKS_P(PT), .RCOSC_DIV_P(DV), .START_CYCLES_P(SC), .FILT_CYCLES_P(FC)) DUT (
    .CLK(clk), .RST(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .POR_PULSE(por), .BROWNOUT_DET(bo), .MASTER_CLEAR_N(master_clear_n_n), .OSCILLATOR_INPUT(osc),
    .OSC_MODE(osc_mode), .POWER_UP_TIMER_ENABLE_N(pte_n), .BROWNOUT_ENABLE_CFG(bo_en),
    .SLEEP_ENTER(sleep_in), .WATCHDOG_TIMEOUT(wdog), .WAKE_IRQ(wake),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .CUR_PC(cur_pc), .CHIP_RESET(chip_reset), .CPU_RUN(cpu_run),
    .PC_LOAD(pc_load), .PC_VALUE(pc_value), .STATUS_LOAD(status_load),
    .STATUS_VALUE(status_value), .STATUS_KEEP(status_keep), .TIMEOUT_FLAG_N(to_n),
    .POWERDOWN_FLAG_N(pd_n));

  rts_partner u_far (.por_pulse(por), .brownout_det(bo), .master_clear_n(master_clear_n_n), .osc_in(osc));

  task check_load(input logic [30:0] e);
    comparisons++;
    if (load_seen !== {2'b10, e}) begin
      err_count++;
      $display("ERROR load expected %h seen %h", {2'b10, e}, load_seen);
    end
  endtask : check_load

  task check_reg(input logic [33:0] e);
    comparisons++;
    if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
      err_count++;
      $display("ERROR apb expected %h seen %h", e[32:0], {pslverr, prdata});
    end
  endtask : check_reg

  task check_time(input string what, input int lo, input int hi, input int n);
    comparisons++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask : check_time

  // A load with nothing noted compares against unknown and so always fails.
  always @(posedge clk) begin
    if (pc_load === 1'b1) check_load(load_q.size() > 0 ? load_q.pop_front() : 31'bx);
    if (pready === 1'b1) check_reg(apb_q.size() > 0 ? apb_q.pop_front() : 34'bx);
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    apb_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wait_run(input string what, input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n <= hi) begin
      @(posedge clk);
      n++;
    end
    check_time(what, lo, hi, n);
  endtask : wait_run

  task stay(input string what, input logic v, input int k);
    int n;
    n = 0;
    repeat (k) begin
      @(posedge clk);
      if (cpu_run !== v || chip_reset !== !v) n++;
    end
    check_time(what, 0, 0, n);
  endtask : stay

  task por_seq(input logic [1:0] m, input logic p, input logic b, input logic hold);
    int d, s;
    rst <= 1'b1;
    u_far.drive(1'b1, 1'b0, 1'b1);
    osc_mode <= m;
    pte_n <= p;
    bo_en <= b;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    d = p ? 0 : PUP;
    s = (m == 2'h3) ? 0 : 1;
    load_q.push_back({13'h0, 8'h18, 8'h07, 2'b11});
    u_far.drive(1'b0, 1'b0, !hold);
    if (hold) begin
      stay("master_clear_n_hold", 1'b0, d + SC * 5 + 40);
      u_far.drive(1'b0, 1'b0, 1'b1);
      wait_run("master_clear_n_release", 1, 12);
    end else begin
      wait_run("power_up", d + s * (SC - 1) * 4, d + s * SC * 5 + 12);
    end
    apb(1'b0, 8'h00, 32'h0, {2'b10, 32'h1});
  endtask : por_seq

  task ev(input int kind, input logic slp, input int pcs, input logic [7:0] sv,
          input logic [7:0] sk, input logic [1:0] fl);
    logic [12:0] pcv;
    pcv = 13'($urandom);
    cur_pc <= pcv;
    global_irq_enable <= (pcs == 2);
    if (slp) begin
      sleep_in <= 1'b1;
      @(posedge clk);
      sleep_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    load_q.push_back({pcs == 0 ? 13'h0 : (pcs == 1 ? pcv + 13'h1 : 13'h4), sv, sk, fl});
    if (kind == 0) wdog <= 1'b1;
    else if (kind == 1) wake <= 1'b1;
    else u_far.drive(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    wdog <= 1'b0;
    wake <= 1'b0;
    if (kind == 2) begin
      repeat (9) @(posedge clk);
      u_far.drive(1'b0, 1'b0, 1'b1);
    end
    repeat (60) @(posedge clk);
    stay("resume", 1'b1, 1);
  endtask : ev

  task results;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // Every mode and delay setting, each run with brown-out on only when the delay is on.
  initial begin
    void'($urandom(32'hd77c));
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        por_seq(2'(m), p[0], !p[0], 1'b0);
        if (p == 1) begin
          u_far.drive(1'b0, 1'b1, 1'b1);
          stay("bo_off", 1'b1, 20);
          u_far.drive(1'b0, 1'b0, 1'b1);
        end
      end
    end
    por_seq(2'h3, 1'b0, 1'b1, 1'b1);
    apb(1'b1, 8'h00, 32'h3, 34'h0);
    apb(1'b0, 8'h00, 32'h0, {2'b10, 32'h3});
    apb(1'b0, 8'h08, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 8'h04, 32'hffff_ffff, 34'h0);
    apb(1'b0, 8'h04, 32'h0, {2'b10, 32'h340});
    u_far.drive(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    u_far.drive(1'b0, 1'b0, 1'b1);
    stay("master_clear_n_glitch", 1'b1, 20);
    ev(2, 1'b0, 0, 8'h00, 8'h1f, 2'b11);
    ev(0, 1'b0, 0, 8'h08, 8'h07, 2'b01);
    ev(0, 1'b1, 1, 8'h00, 8'he7, 2'b00);
    ev(1, 1'b1, 2, 8'h10, 8'he7, 2'b10);
    ev(2, 1'b0, 0, 8'h00, 8'h1f, 2'b10);
    ev(1, 1'b1, 1, 8'h10, 8'he7, 2'b10);
    ev(2, 1'b1, 0, 8'h10, 8'h07, 2'b10);
    u_far.drive(1'b0, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    stay("bo_hold", 1'b0, 10);
    u_far.drive(1'b0, 1'b0, 1'b1);
    stay("bo_delay", 1'b0, 40);
    u_far.drive(1'b0, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    load_q.push_back({13'h0, 8'h18, 8'h07, 2'b11});
    u_far.drive(1'b0, 1'b0, 1'b1);
    wait_run("bo_restart", PUP, PUP + 12);
    apb(1'b0, 8'h00, 32'h0, {2'b10, 32'h2});
    por_seq(2'h1, 1'b1, 1'b0, 1'b0);
    ev(1, 1'b1, 1, 8'h10, 8'he7, 2'b10);
    check_time("pending", 0, 0, load_q.size() + apb_q.size());
    results();
  end

  // The whole run needs a few thousand cycles; this limit is far beyond it.
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule : rts_top_tb
